// File: hw/sfc_defines.svh
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define SFC_OP_WPERM_SET    8'h06
`define SFC_OP_WPERM_CLR    8'h04
`define SFC_OP_STAT_RD      8'h05
`define SFC_OP_CFG_RD       8'h15
`define SFC_OP_STAT_CFG_WR  8'h01
`define SFC_OP_UADDR_RD     8'hc8
`define SFC_OP_UADDR_WR     8'hc5
`define SFC_OP_PROT_SEL     8'h68
`define SFC_OP_QUAD_ENTER   8'h35
`define SFC_OP_QUAD_EXIT    8'hf5
`define SFC_OP_WIDE_ENTER   8'hb7
`define SFC_OP_WIDE_EXIT    8'he9
`define SFC_OP_PAUSE_A      8'hb0
`define SFC_OP_PAUSE_B      8'h75
`define SFC_OP_CONT_A       8'h30
`define SFC_OP_CONT_B       8'h7a
`define SFC_OP_PD_ENTER     8'hb9
`define SFC_OP_PD_RELEASE   8'hab
`define SFC_OP_BURST_SET    8'hc0
`define SFC_OP_BOOT_RD      8'h16
`define SFC_OP_BOOT_WR      8'h17
`define SFC_OP_BOOT_ERASE   8'h18

// ----------------------------------------------------------------------
// frame byte counts (opcode included)
// ----------------------------------------------------------------------
`define SFC_LEN_OPCODE      3'h1
`define SFC_LEN_ONE_DATA    3'h2
`define SFC_LEN_TWO_DATA    3'h3
`define SFC_LEN_FOUR_DATA   3'h5
`define SFC_LEN_MAX         3'h7

// ----------------------------------------------------------------------
// field positions, widths and reset values
// ----------------------------------------------------------------------
`define SFC_ST_BUSY_BIT     0
`define SFC_ST_WPERM_BIT    1
`define SFC_CFG_DUMMY_HI    7
`define SFC_CFG_DUMMY_LO    6
`define SFC_BITS_SINGLE     3'h1
`define SFC_BITS_QUAD       3'h4
`define SFC_ADDR_BYTES_STD  3'h3
`define SFC_ADDR_BYTES_WIDE 3'h4
`define SFC_STATUS_RST      8'h00
`define SFC_CONFIG_RST      8'h00
`define SFC_UADDR_RST       8'h00
`define SFC_BURST_RST       8'h00
`define SFC_BOOT_RST        32'hffff_ffff
`define SFC_BOOT_ERASED     32'hffff_ffff
`define SFC_SO_LANE         1
`define SFC_SI_LANE         0

`endif

// File: hw/sfc_pkg.sv
package sfc_pkg;

    // one captured frame as seen at chip-select release
    typedef struct packed {
        logic [7:0] opcode;
        logic [31:0] data;   // last data bytes, newest in [7:0]
        logic [2:0] nbytes;  // bytes incl. opcode, saturating
        logic frag;          // frame ended inside a byte
    } sfc_frame_s;

    // readout word and whether it is driven
    typedef struct packed {
        logic en;
        logic [31:0] word;
    } sfc_tx_s;

endpackage : sfc_pkg

// File: hw/sfc_setting_decoder.sv
//
// Contract
// - complete opcode 06h sets the write-permission latch.
// - complete opcode 04h clears the write-permission latch.
// - opcode 05h shifts out the status register.
// - opcode 15h shifts out the configuration register.
// - opcode 01h plus one or two bytes loads status then configuration.
// - opcode C8h shifts out the upper-address register.
// - opcode C5h with exactly one byte loads the upper-address register.
// - opcode 68h, single-line only, enables individual block protection.
// - opcode F5h, four-line mode only, returns to single-line mode.
// - opcode B7h sets the address-width flag.
// - opcode E9h clears the address-width flag.
// - opcode B0h or 75h requests program/erase suspend.
// - opcode 30h or 7Ah requests program/erase resume.
// - opcode B9h enters deep power-down.
// - opcode ABh leaves deep power-down.
// - opcode C0h updates the burst length setting.
// - boot register: 16h reads 1-4 bytes, 17h writes four, 18h erases.
// - boot register commands only in single-line mode.
// - protect-select and quad-enter single-line only, quad-exit quad only.
// - address-width flag selects four instead of three address bytes.
// - configuration bits 7:6 select read dummy cycles.
//
`timescale 1ns/1ns
`default_nettype none
`include "sfc_defines.svh"

module sfc_setting_decoder import sfc_pkg::*; (
    // system clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // serial link
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_out,
    // settings towards the array logic
    output logic write_permit_latch_out,
    output logic addr_width_flag_out,
    output logic [2:0] addr_bytes_out,
    output logic quad_command_mode_out,
    output logic [1:0] dummy_count_out,
    output logic [7:0] status_out,
    output logic [7:0] config_out,
    output logic [7:0] upper_addr_out,
    output logic [7:0] burst_len_out,
    output logic [31:0] boot_reg_out,
    output logic protect_indiv_out,
    output logic power_down_out,
    output logic pause_pulse_out,
    output logic continue_pulse_out
);

    // ------------------------------------------------------------------
    // reset release and chip-select synchroniser
    // ------------------------------------------------------------------
    logic rst_meta_reg, rst_sys_n;
    logic cs_meta_reg, cs_sync_reg, cs_prev_reg;
    logic cs_rise;

    // reset released through two flops
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sys_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sys_n <= rst_meta_reg;
        end
    end

    // chip select brought into the system domain
    always_ff @(posedge clk_sys_in or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else begin
            cs_meta_reg <= cs_n_in;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
        end
    end

    assign cs_rise = cs_sync_reg && !cs_prev_reg;

    // ------------------------------------------------------------------
    // setting registers (system domain)
    // ------------------------------------------------------------------
    logic wperm_reg, wide_reg, quad_reg, prot_reg, pd_reg;
    logic [7:0] status_reg, config_reg, uaddr_reg, burst_reg;
    logic [31:0] boot_reg;

    // ------------------------------------------------------------------
    // link side: bit counter, receive and transmit (link clock)
    // ------------------------------------------------------------------
    sfc_frame_s frame_reg;
    sfc_tx_s tx_reg;
    logic [2:0] bit_cnt_reg, bit_step, bit_cnt_next;
    logic started_reg, byte_done;
    logic [7:0] rx_sh_reg, rx_byte;
    logic [2:0] base_cnt;
    sfc_tx_s tx_next;

    // quad mode and the other settings are stable while the frame runs
    assign bit_step = quad_reg ? `SFC_BITS_QUAD : `SFC_BITS_SINGLE;
    assign bit_cnt_next = bit_cnt_reg + bit_step;
    assign byte_done = (bit_cnt_next == 3'h0);
    assign rx_byte = quad_reg ? {rx_sh_reg[3:0], io_in} : {rx_sh_reg[6:0], io_in[`SFC_SI_LANE]};
    assign base_cnt = started_reg ? frame_reg.nbytes : 3'h0;

    // readout choice, made as the opcode byte completes
    always_comb begin
        tx_next.en = 1'b0;
        tx_next.word = 32'h0;
        if (!pd_reg) begin
            if (rx_byte == `SFC_OP_STAT_RD) begin
                tx_next.en = 1'b1;
                tx_next.word = {4{status_out}};
            end else if (rx_byte == `SFC_OP_CFG_RD) begin
                tx_next.en = 1'b1;
                tx_next.word = {4{config_reg}};
            end else if (rx_byte == `SFC_OP_UADDR_RD) begin
                tx_next.en = 1'b1;
                tx_next.word = {4{uaddr_reg}};
            end else if (rx_byte == `SFC_OP_BOOT_RD && !quad_reg) begin
                tx_next.en = 1'b1;
                tx_next.word = boot_reg;
            end
        end
    end

    // per-frame state, cleared by the frame's own select
    always_ff @(posedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            bit_cnt_reg <= 3'h0;
            started_reg <= 1'b0;
            tx_reg <= '0;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            started_reg <= 1'b1;
            if (byte_done && base_cnt == 3'h0) begin
                tx_reg <= tx_next;
            end else if (tx_reg.en) begin
                // rotate so short registers repeat until select rises
                if (quad_reg) begin
                    tx_reg.word <= {tx_reg.word[27:0], tx_reg.word[31:28]};
                end else begin
                    tx_reg.word <= {tx_reg.word[30:0], tx_reg.word[31]};
                end
            end
        end
    end

    // captured frame, kept across select release for the system domain
    always_ff @(posedge sclk_in or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            rx_sh_reg <= 8'h0;
            frame_reg <= '0;
        end else begin
            rx_sh_reg <= rx_byte;
            frame_reg.frag <= !byte_done;
            if (byte_done) begin
                if (base_cnt == 3'h0) begin
                    frame_reg.opcode <= rx_byte;
                end else begin
                    frame_reg.data <= {frame_reg.data[23:0], rx_byte};
                end
                if (base_cnt != `SFC_LEN_MAX) begin
                    frame_reg.nbytes <= base_cnt + 3'h1;
                end
            end else if (!started_reg) begin
                frame_reg.nbytes <= 3'h0;
            end
        end
    end

    // output pins change on the falling link edge
    always_ff @(negedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            io_out <= 4'h0;
            io_oe_out <= 4'h0;
        end else if (quad_reg) begin
            io_out <= tx_reg.word[31:28];
            io_oe_out <= {4{tx_reg.en}};
        end else begin
            io_out <= {2'b00, tx_reg.word[31], 1'b0};
            io_oe_out <= {2'b00, tx_reg.en, 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // command decode at chip-select release
    // ------------------------------------------------------------------
    logic go;
    logic [7:0] op;
    logic [2:0] nb;

    // whole bytes only; in power-down only the release opcode counts
    assign op = frame_reg.opcode;
    assign nb = frame_reg.nbytes;
    assign go = cs_rise && !frame_reg.frag && nb != 3'h0 &&
                (!pd_reg || op == `SFC_OP_PD_RELEASE);

    function automatic logic hit(input logic [7:0] code, input logic [2:0] len);
        hit = go && op == code && nb == len;
    endfunction : hit

    // write-permission latch
    always_ff @(posedge clk_sys_in or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            wperm_reg <= 1'b0;
        end else if (hit(`SFC_OP_WPERM_SET, `SFC_LEN_OPCODE)) begin
            wperm_reg <= 1'b1;
        end else if (hit(`SFC_OP_WPERM_CLR, `SFC_LEN_OPCODE)) begin
            wperm_reg <= 1'b0;
        end else if (wperm_reg && (hit(`SFC_OP_STAT_CFG_WR, `SFC_LEN_ONE_DATA) ||
                     hit(`SFC_OP_STAT_CFG_WR, `SFC_LEN_TWO_DATA) ||
                     hit(`SFC_OP_UADDR_WR, `SFC_LEN_ONE_DATA) ||
                     (!quad_reg && (hit(`SFC_OP_BOOT_WR, `SFC_LEN_FOUR_DATA) ||
                     hit(`SFC_OP_BOOT_ERASE, `SFC_LEN_OPCODE))))) begin
            wperm_reg <= 1'b0;
        end
    end

    // status and configuration write
    always_ff @(posedge clk_sys_in or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            status_reg <= `SFC_STATUS_RST;
            config_reg <= `SFC_CONFIG_RST;
        end else if (wperm_reg && hit(`SFC_OP_STAT_CFG_WR, `SFC_LEN_ONE_DATA)) begin
            status_reg <= frame_reg.data[7:0];
        end else if (wperm_reg && hit(`SFC_OP_STAT_CFG_WR, `SFC_LEN_TWO_DATA)) begin
            status_reg <= frame_reg.data[15:8];
            config_reg <= frame_reg.data[7:0];
        end
    end

    // upper-address and burst length
    always_ff @(posedge clk_sys_in or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            uaddr_reg <= `SFC_UADDR_RST;
            burst_reg <= `SFC_BURST_RST;
        end else begin
            if (wperm_reg && hit(`SFC_OP_UADDR_WR, `SFC_LEN_ONE_DATA)) begin
                uaddr_reg <= frame_reg.data[7:0];
            end
            if (hit(`SFC_OP_BURST_SET, `SFC_LEN_ONE_DATA)) begin
                burst_reg <= frame_reg.data[7:0];
            end
        end
    end

    // boot register write and erase, single-line only
    always_ff @(posedge clk_sys_in or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            boot_reg <= `SFC_BOOT_RST;
        end else if (wperm_reg && !quad_reg && hit(`SFC_OP_BOOT_WR, `SFC_LEN_FOUR_DATA)) begin
            boot_reg <= frame_reg.data;
        end else if (wperm_reg && !quad_reg && hit(`SFC_OP_BOOT_ERASE, `SFC_LEN_OPCODE)) begin
            boot_reg <= `SFC_BOOT_ERASED;
        end
    end

    // command mode, protection scheme and address width
    always_ff @(posedge clk_sys_in or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            quad_reg <= 1'b0;
            prot_reg <= 1'b0;
            wide_reg <= 1'b0;
        end else begin
            if (!quad_reg && hit(`SFC_OP_QUAD_ENTER, `SFC_LEN_OPCODE)) begin
                quad_reg <= 1'b1;
            end else if (quad_reg && hit(`SFC_OP_QUAD_EXIT, `SFC_LEN_OPCODE)) begin
                quad_reg <= 1'b0;
            end
            if (!quad_reg && wperm_reg && hit(`SFC_OP_PROT_SEL, `SFC_LEN_OPCODE)) begin
                prot_reg <= 1'b1;
            end
            if (hit(`SFC_OP_WIDE_ENTER, `SFC_LEN_OPCODE)) begin
                wide_reg <= 1'b1;
            end else if (hit(`SFC_OP_WIDE_EXIT, `SFC_LEN_OPCODE)) begin
                wide_reg <= 1'b0;
            end
        end
    end

    // deep power-down and suspend/resume pulses
    always_ff @(posedge clk_sys_in or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            pd_reg <= 1'b0;
            pause_pulse_out <= 1'b0;
            continue_pulse_out <= 1'b0;
        end else begin
            if (hit(`SFC_OP_PD_ENTER, `SFC_LEN_OPCODE)) begin
                pd_reg <= 1'b1;
            end else if (hit(`SFC_OP_PD_RELEASE, `SFC_LEN_OPCODE)) begin
                pd_reg <= 1'b0;
            end
            pause_pulse_out <= hit(`SFC_OP_PAUSE_A, `SFC_LEN_OPCODE) ||
                               hit(`SFC_OP_PAUSE_B, `SFC_LEN_OPCODE);
            continue_pulse_out <= hit(`SFC_OP_CONT_A, `SFC_LEN_OPCODE) ||
                                  hit(`SFC_OP_CONT_B, `SFC_LEN_OPCODE);
        end
    end

    // ------------------------------------------------------------------
    // registered copies on the output ports
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            write_permit_latch_out <= 1'b0;
            addr_width_flag_out <= 1'b0;
            addr_bytes_out <= `SFC_ADDR_BYTES_STD;
            quad_command_mode_out <= 1'b0;
            dummy_count_out <= 2'b00;
            status_out <= `SFC_STATUS_RST;
            config_out <= `SFC_CONFIG_RST;
            upper_addr_out <= `SFC_UADDR_RST;
            burst_len_out <= `SFC_BURST_RST;
            boot_reg_out <= `SFC_BOOT_RST;
            protect_indiv_out <= 1'b0;
            power_down_out <= 1'b0;
        end else begin
            write_permit_latch_out <= wperm_reg;
            addr_width_flag_out <= wide_reg;
            addr_bytes_out <= wide_reg ? `SFC_ADDR_BYTES_WIDE : `SFC_ADDR_BYTES_STD;
            quad_command_mode_out <= quad_reg;
            dummy_count_out <= config_reg[`SFC_CFG_DUMMY_HI:`SFC_CFG_DUMMY_LO];
            status_out <= status_reg;
            status_out[`SFC_ST_WPERM_BIT] <= wperm_reg;
            status_out[`SFC_ST_BUSY_BIT] <= 1'b0;
            config_out <= config_reg;
            upper_addr_out <= uaddr_reg;
            burst_len_out <= burst_reg;
            boot_reg_out <= boot_reg;
            protect_indiv_out <= prot_reg;
            power_down_out <= pd_reg;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_set_cmd;
        hit(`SFC_OP_WPERM_SET, `SFC_LEN_OPCODE);
    endsequence

    sequence s_latch_seen;
        ##1 wperm_reg ##1 write_permit_latch_out;
    endsequence

    a_wperm_set_seen: assert property (@(posedge clk_sys_in) disable iff (!rst_sys_n)
        s_set_cmd |-> s_latch_seen) else $error("latch not set by opcode 06h");

    a_wperm_clr_cmd: assert property (@(posedge clk_sys_in) disable iff (!rst_sys_n)
        hit(`SFC_OP_WPERM_CLR, `SFC_LEN_OPCODE) |=> !wperm_reg ##1 !write_permit_latch_out)
        else $error("latch not cleared by opcode 04h");

    a_act_on_release: assert property (@(posedge clk_sys_in) disable iff (!rst_sys_n)
        ($changed(wperm_reg) || $changed(config_reg) || $changed(wide_reg)) |-> $past(cs_rise))
        else $error("setting changed without a select release");

    a_status_write: assert property (@(posedge clk_sys_in) disable iff (!rst_sys_n)
        wperm_reg && hit(`SFC_OP_STAT_CFG_WR, `SFC_LEN_TWO_DATA) |=>
        status_reg == $past(frame_reg.data[15:8]) && config_reg == $past(frame_reg.data[7:0]))
        else $error("two-byte status write wrong");

    a_write_locked: assert property (@(posedge clk_sys_in) disable iff (!rst_sys_n)
        !wperm_reg |=> $stable(config_reg) && $stable(uaddr_reg) && $stable(boot_reg))
        else $error("register written without latch");

    a_quad_gate: assert property (@(posedge clk_sys_in) disable iff (!rst_sys_n)
        $rose(quad_reg) |-> $past(op == `SFC_OP_QUAD_ENTER && go && !quad_reg))
        else $error("four-line mode entered wrongly");

    a_quad_exit: assert property (@(posedge clk_sys_in) disable iff (!rst_sys_n)
        quad_reg && hit(`SFC_OP_QUAD_EXIT, `SFC_LEN_OPCODE) |=> !quad_reg ##1 !quad_command_mode_out)
        else $error("four-line mode not left");

    a_wide_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_sys_n)
        hit(`SFC_OP_WIDE_ENTER, `SFC_LEN_OPCODE) |=> ##1 addr_bytes_out == `SFC_ADDR_BYTES_WIDE)
        else $error("four address bytes not selected");

    a_boot_erase: assert property (@(posedge clk_sys_in) disable iff (!rst_sys_n)
        wperm_reg && !quad_reg && hit(`SFC_OP_BOOT_ERASE, `SFC_LEN_OPCODE) |=>
        boot_reg == `SFC_BOOT_ERASED) else $error("boot register not erased");

    a_pd_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_sys_n)
        pd_reg && !(cs_rise && op == `SFC_OP_PD_RELEASE) |=> pd_reg && $stable(wide_reg))
        else $error("command acted during power-down");

    a_pause_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_sys_n)
        pause_pulse_out |-> !$past(pause_pulse_out) ##1 !pause_pulse_out)
        else $error("suspend pulse longer than a cycle");

endmodule : sfc_setting_decoder
`default_nettype wire

// File: verification/sfc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// host serial controller: one command per select-low period
module sfc_host_model (
    // link pins
    output logic sclk_out,
    output logic cs_n_out,
    output logic [3:0] io_drv_out,
    // resolved data lines
    input wire logic [3:0] io_wire_in
);
    // ----------------------------------------------------------------------
    // idle: clock parked low, select high
    // ----------------------------------------------------------------------
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        io_drv_out = 4'h5;
    end
    // ----------------------------------------------------------------------
    // frame: opcode, nd data bytes, then nrd bytes read back
    // ----------------------------------------------------------------------
    task automatic xfer(input logic [7:0] op, input logic [31:0] wd, input int nd,
                        input logic quad, input int nrd, output logic [31:0] rd);
        logic [39:0] sh;
        int stp;
        sh = {op, wd << (8 * (4 - nd))};
        stp = quad ? 4 : 1;
        rd = 32'h0;
        #7 cs_n_out <= 1'b0; // no address bytes, one frame
        for (int k = 0; k < 8 * (1 + nd) / stp; k++) begin
            io_drv_out <= quad ? sh[39:36] : {~io_drv_out[3:1], sh[39]};
            #80 sclk_out <= 1'b1;
            #80 sclk_out <= 1'b0;
            sh = sh << stp;
        end
        for (int k = 0; k < 8 * nrd / stp; k++) begin
            io_drv_out <= ~io_drv_out; // released lines never hold a value
            #80 sclk_out <= 1'b1;
            rd = quad ? {rd[27:0], io_wire_in} : {rd[30:0], io_wire_in[1]};
            #80 sclk_out <= 1'b0;
        end
        #80 cs_n_out <= 1'b1;
        io_drv_out <= ~io_drv_out;
    endtask : xfer
endmodule : sfc_host_model
`default_nettype wire

// File: verification/tb_sfc_setting_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
    $display("Error at %0t: got %0h exp %0h", $time, a, e); end end
module tb_sfc_setting_decoder;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, quad = 1'b0;
    wire sclk_in, cs_n_in;
    wire [3:0] io_in;
    logic [3:0] host_io, io_out, io_oe_out;
    logic write_permit_latch_out, addr_width_flag_out, quad_command_mode_out;
    logic protect_indiv_out, power_down_out, pause_pulse_out, continue_pulse_out;
    logic [2:0] addr_bytes_out;
    logic [1:0] dummy_count_out;
    logic [7:0] status_out, config_out, upper_addr_out, burst_len_out;
    logic [31:0] boot_reg_out, rd;
    int err_total = 0, checked = 0, n_pause = 0, n_cont = 0;
    // ----------------------------------------------------------------------
    // clock, wire resolution, pulse counters
    // ----------------------------------------------------------------------
    always #5 clk_sys_in = ~clk_sys_in;
    assign io_in = (io_oe_out & io_out) | (~io_oe_out & host_io);
    always @(posedge clk_sys_in) begin
        n_pause <= n_pause + int'(pause_pulse_out);
        n_cont <= n_cont + int'(continue_pulse_out);
    end
    sfc_setting_decoder u_dut (.clk_sys_in, .rst_n_in, .sclk_in, .cs_n_in, .io_in, .io_out,
        .io_oe_out, .write_permit_latch_out, .addr_width_flag_out, .addr_bytes_out,
        .quad_command_mode_out, .dummy_count_out, .status_out, .config_out, .upper_addr_out,
        .burst_len_out, .boot_reg_out, .protect_indiv_out, .power_down_out, .pause_pulse_out,
        .continue_pulse_out);
    sfc_host_model u_host (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .io_drv_out(host_io),
        .io_wire_in(io_in));
    // ----------------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------------
    task automatic cmd(input logic [7:0] op, input logic [31:0] wd = 0, input int nd = 0,
                       input int nrd = 0);
        u_host.xfer(op, wd, nd, quad, nrd, rd);
        repeat (12) @(posedge clk_sys_in);
    endtask : cmd
    task automatic complete_run();
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    // watchdog: the sequence needs about 7,100 system cycles, allow over five times that
    initial begin
        #400000;
        err_total++;
        complete_run();
    end
    // ----------------------------------------------------------------------
    // command sequence
    // ----------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        `CHK({addr_bytes_out, boot_reg_out}, {3'h3, 32'hffff_ffff})
        cmd(8'h06);
        `CHK({write_permit_latch_out, status_out[1]}, 2'h3)
        cmd(8'h04);
        `CHK(write_permit_latch_out, 1'b0)
        cmd(8'h01, 32'hfcc0, 2);
        `CHK(config_out, 8'h00)
        cmd(8'h06);
        cmd(8'h01, 32'hfcc0, 2);
        `CHK({status_out, config_out, dummy_count_out}, {16'hfcc0, 2'h3})
        cmd(8'h05, 0, 0, 2);
        `CHK(rd[15:0], 16'hfcfc)
        cmd(8'h15, 0, 0, 1);
        `CHK(rd[7:0], 8'hc0)
        cmd(8'h06);
        cmd(8'hc5, 32'h5a, 1);
        cmd(8'hc8, 0, 0, 1);
        `CHK(rd[7:0], 8'h5a)
        cmd(8'h06);
        cmd(8'hc5, 32'h3c3c, 2);
        `CHK(upper_addr_out, 8'h5a)
        cmd(8'hb7);
        `CHK({addr_width_flag_out, addr_bytes_out}, 4'hc)
        cmd(8'he9);
        `CHK({addr_width_flag_out, addr_bytes_out}, 4'h3)
        cmd(8'hc0, 32'h12, 1);
        `CHK(burst_len_out, 8'h12)
        cmd(8'hb0);
        cmd(8'h75);
        cmd(8'h30);
        cmd(8'h7a);
        `CHK({n_pause, n_cont}, {32'sd2, 32'sd2})
        cmd(8'h17, 32'h1122_3344, 4);
        cmd(8'h16, 0, 0, 4);
        `CHK(rd, 32'h1122_3344)
        cmd(8'h35);
        `CHK(quad_command_mode_out, 1'b1)
        quad = 1'b1;
        cmd(8'h06);
        cmd(8'h68);
        cmd(8'h18);
        cmd(8'h35);
        `CHK({protect_indiv_out, boot_reg_out}, {1'b0, 32'h1122_3344})
        cmd(8'h05, 0, 0, 1);
        `CHK(rd[7:0], 8'hfe)
        cmd(8'hf5);
        quad = 1'b0;
        `CHK(quad_command_mode_out, 1'b0)
        cmd(8'h68);
        `CHK(protect_indiv_out, 1'b1)
        cmd(8'h06);
        cmd(8'h18);
        `CHK(boot_reg_out, 32'hffff_ffff)
        cmd(8'hb9);
        cmd(8'h06);
        `CHK({power_down_out, write_permit_latch_out}, 2'h2)
        cmd(8'hab);
        `CHK(power_down_out, 1'b0)
        complete_run();
    end
endmodule : tb_sfc_setting_decoder
`default_nettype wire
